// >>> rcp_cmd_port.sv
// Three-wire command port and register store of the calendar clock
//
// Contract
// - Three command bits then direction bit.
// - Data bytes move B7 first.
// - Wrong preamble means no action at all.
// - Later byte matching preamble still executes.
// - Command 000 reaches first status byte.
// - Command 001 reaches second status byte.
// - Command 010 moves seven time bytes.
// - Command 011 moves hour, minute, second.
// - Alarm-one mode: three match bytes.
// - Frequency mode: one frequency select byte.
// - Command 101 moves three alarm-two bytes.
// - Command 110 moves correction byte.
// - Command 111 moves free retained byte.
// - Software reset initialises, reads zero.
// - Scratch bits hold written values.
// - Alarm flags set on match, clear on read.
// - Power-on flag set at power, clears on read.
// - Unused bits ignore writes, read zero.
// - Time bytes held as BCD, seven bytes.
// - Status-two bits choose interrupt pin mode.
`default_nettype none
module rcp_cmd_port
  import rcp_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire logic           cs_pin,
  input  wire logic           sck_pin,
  input  wire logic           sio_i,
  output logic                sio_o,
  output logic                sio_oe,
  input  wire logic           alarm_one_hit,
  input  wire logic           alarm_two_hit,
  input  wire logic           low_voltage_det,
  output logic                hour_24_mode,
  output logic [7:0]          status_two,
  output logic [55:0]         time_date,
  output logic [23:0]         alarm_one_reg,
  output logic [23:0]         alarm_two_reg,
  output logic [7:0]          rate_correction,
  output logic [7:0]          user_free_byte,
  output var rcp_int_mode_t   int_mode,
  output logic                init_pulse
);

  // ==========================================================================
  // Link front end
  rcp_link_if lnk ();

  rcp_link_sync #(
    .SYNC_STAGES (SYNC_STAGES)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .cs_pin  (cs_pin),
    .sck_pin (sck_pin),
    .sio_pin (sio_i),
    .lnk     (lnk)
  );

  // ==========================================================================
  // State
  rcp_state_t    state_q,  state_d;
  logic [2:0]    bit_q,    bit_d;
  logic [7:0]    sh_q,     sh_d;
  logic [2:0]    byte_q,   byte_d;
  logic [2:0]    cmd_q,    cmd_d;
  logic [7:0]    tx_q,     tx_d;
  logic          oe_q,     oe_d;
  logic [7:0]    mem_q [MEM_BYTES];
  logic [7:0]    mem_d [MEM_BYTES];
  logic          fmt_q,    fmt_d;
  logic [1:0]    sc_q,     sc_d;
  logic          a1f_q,    a1f_d;
  logic          a2f_q,    a2f_d;
  logic          lvf_q,    lvf_d;
  logic          poc_q,    poc_d;
  logic          init_q,   init_d;
  rcp_int_mode_t mode_q,   mode_d;

  logic [7:0]    rx_byte;
  logic          byte_end;
  logic          freq_mode;
  logic          alarm1_mode;
  logic          hunt_hit;
  logic [2:0]    rd_cmd;
  logic [3:0]    rd_idx;
  logic [7:0]    rd_val;
  logic          rd_st1;
  logic          wr_stb;
  logic [3:0]    wr_idx;

  // ==========================================================================
  // Byte framing and read data selection
  always_comb begin
    rx_byte     = {sh_q[6:0], lnk.din};
    byte_end    = lnk.sel && lnk.rise && (bit_q == 3'h7);
    freq_mode   = mem_q[IDX_STAT2][ST2_FREQ] & ~mem_q[IDX_STAT2][ST2_PMIN];
    alarm1_mode = mem_q[IDX_STAT2][ST2_A1EN] & ~mem_q[IDX_STAT2][ST2_PMIN]
                  & ~mem_q[IDX_STAT2][ST2_FREQ];
    // Any byte boundary while hunting may carry the command
    hunt_hit    = byte_end && (state_q == ST_HUNT)
                  && (rx_byte[7:4] == PREAMBLE);
    rd_cmd      = (state_q == ST_HUNT) ? rx_byte[3:1] : cmd_q;
    rd_idx      = (state_q == ST_HUNT) ? 4'h0 : {1'b0, byte_q} + 4'h1;
    if (rd_idx >= cmd_len(rd_cmd, freq_mode)) begin
      rd_val = 8'h00;
    end else if (rd_cmd == CMD_STAT1) begin
      // Reset bit always reads zero
      rd_val = {1'b0, fmt_q, sc_q, a1f_q, a2f_q, lvf_q, poc_q};
    end else begin
      rd_val = mem_q[cmd_base(rd_cmd) + rd_idx];
    end
    rd_st1 = byte_end && (rd_cmd == CMD_STAT1) && (rd_idx == 4'h0)
             && ((hunt_hit && rx_byte[0]) || (state_q == ST_READ));
    wr_stb = byte_end && (state_q == ST_WRITE)
             && ({1'b0, byte_q} < cmd_len(cmd_q, freq_mode));
    wr_idx = cmd_base(cmd_q) + {1'b0, byte_q};
  end

  // ==========================================================================
  // Serial sequencer; deselect always drops back to hunting
  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    byte_d  = byte_q;
    cmd_d   = cmd_q;
    tx_d    = tx_q;
    oe_d    = oe_q;
    if (!lnk.sel) begin
      state_d = ST_HUNT;
      bit_d   = 3'h0;
      byte_d  = 3'h0;
      oe_d    = 1'b0;
    end else if (lnk.rise) begin
      sh_d  = rx_byte;
      bit_d = bit_q + 3'h1;
      if (hunt_hit) begin
        cmd_d   = rx_byte[3:1];
        byte_d  = 3'h0;
        state_d = rx_byte[0] ? ST_READ : ST_WRITE;
        tx_d    = rd_val;
      end else if (byte_end && (state_q != ST_HUNT)) begin
        // Saturate so surplus bytes stay beyond the transfer
        byte_d = (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
        tx_d   = rd_val;
      end
    end else if (lnk.fall && (state_q == ST_READ)) begin
      // Open drain: enable pulls low for a zero bit
      oe_d = ~tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
  end

  // ==========================================================================
  // Register store, flags and initialisation
  always_comb begin
    mem_d  = mem_q;
    fmt_d  = fmt_q;
    sc_d   = sc_q;
    init_d = 1'b0;
    if (wr_stb && (cmd_q == CMD_STAT1)) begin
      init_d = rx_byte[ST1_RESET];
      fmt_d  = rx_byte[ST1_FMT];
      sc_d   = {rx_byte[ST1_SC0], rx_byte[ST1_SC1]};
    end else if (wr_stb) begin
      // Time bytes are stored as written with unused bits masked to zero, BCD is the host's to keep
      mem_d[wr_idx] = rx_byte & mem_mask(wr_idx, freq_mode);
    end
    // Set beats the read-clear so a match in that cycle survives
    a1f_d = (a1f_q & ~rd_st1) | (alarm_one_hit & alarm1_mode);
    a2f_d = (a2f_q & ~rd_st1)
            | (alarm_two_hit & mem_q[IDX_STAT2][ST2_A2EN]);
    poc_d = poc_q & ~rd_st1;
    lvf_d = lvf_q | low_voltage_det;
    if (init_q) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_d[i] = RST_BYTE;
      end
      fmt_d = 1'b0;
      sc_d  = 2'h0;
      // A match landing on the initialising cycle is still kept
      a1f_d = alarm_one_hit & alarm1_mode;
      a2f_d = alarm_two_hit & mem_q[IDX_STAT2][ST2_A2EN];
    end
  end

  // Interrupt pin mode; the crystal-rate bit overrides all others
  always_comb begin
    casez ({mem_q[IDX_STAT2][ST2_XTAL], mem_q[IDX_STAT2][ST2_A1EN],
            mem_q[IDX_STAT2][ST2_PMIN], mem_q[IDX_STAT2][ST2_FREQ]})
      4'b1???: mode_d = MODE_XTAL;
      4'b0?01: mode_d = MODE_FREQ;
      4'b0?10: mode_d = MODE_MIN_EDGE;
      4'b0011: mode_d = MODE_MIN_PER1;
      4'b0100: mode_d = MODE_ALARM1;
      4'b0111: mode_d = MODE_MIN_PER2;
      default: mode_d = MODE_NONE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_HUNT;
      bit_q   <= 3'h0;
      sh_q    <= RST_BYTE;
      byte_q  <= 3'h0;
      cmd_q   <= 3'h0;
      tx_q    <= RST_BYTE;
      oe_q    <= 1'b0;
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_q[i] <= RST_BYTE;
      end
      fmt_q   <= 1'b0;
      sc_q    <= 2'h0;
      a1f_q   <= 1'b0;
      a2f_q   <= 1'b0;
      lvf_q   <= 1'b0;
      poc_q   <= RST_POC;
      init_q  <= 1'b0;
      mode_q  <= MODE_NONE;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      byte_q  <= byte_d;
      cmd_q   <= cmd_d;
      tx_q    <= tx_d;
      oe_q    <= oe_d;
      mem_q   <= mem_d;
      fmt_q   <= fmt_d;
      sc_q    <= sc_d;
      a1f_q   <= a1f_d;
      a2f_q   <= a2f_d;
      lvf_q   <= lvf_d;
      poc_q   <= poc_d;
      init_q  <= init_d;
      mode_q  <= mode_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign sio_o           = 1'b0;
  assign sio_oe          = oe_q;
  assign hour_24_mode    = fmt_q;
  assign status_two      = mem_q[IDX_STAT2];
  assign time_date       = {mem_q[1], mem_q[2], mem_q[3], mem_q[4],
                            mem_q[5], mem_q[6], mem_q[7]};
  assign alarm_one_reg   = {mem_q[8], mem_q[9], mem_q[10]};
  assign alarm_two_reg   = {mem_q[11], mem_q[12], mem_q[13]};
  assign rate_correction = mem_q[IDX_CORR];
  assign user_free_byte  = mem_q[IDX_FREE];
  assign int_mode        = mode_q;
  assign init_pulse      = init_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  poc_read_clear_a: assert property (rd_st1 |=> !poc_q)
    else $error("power-on flag survived a read");
  alarm_read_clear_a: assert property (
    rd_st1 && !alarm_one_hit |=> !a1f_q)
    else $error("alarm one flag survived a read");
  alarm_set_a: assert property (
    alarm_one_hit && alarm1_mode && !init_q |=> a1f_q)
    else $error("alarm one match lost");
  no_cmd_write_a: assert property (
    byte_end && state_q == ST_HUNT && rx_byte[7:4] != PREAMBLE
    |=> state_q == ST_HUNT && !oe_q && !init_q)
    else $error("action taken without recognised command");
  late_hit_a: assert property (
    hunt_hit && !rx_byte[0] |=> state_q == ST_WRITE)
    else $error("recognised write not entered");
  read_dir_a: assert property (
    hunt_hit && rx_byte[0] |=> state_q == ST_READ)
    else $error("recognised read not entered");
  msb_first_a: assert property (
    lnk.sel && lnk.fall && state_q == ST_READ
    |=> sio_oe == !$past(tx_q[7]))
    else $error("serial output bit order wrong");
  month_unused_a: assert property (
    (mem_q[IDX_MONTH] & ~MASK_MONTH) == 8'h00)
    else $error("unused month bits hold data");
  free_keep_a: assert property (
    !(wr_stb && wr_idx == IDX_FREE) && !init_q
    |=> $stable(mem_q[IDX_FREE]))
    else $error("free byte changed without a write");
  init_clear_a: assert property (
    init_q |=> mem_q[IDX_CORR] == RST_BYTE && !fmt_q)
    else $error("initialisation left state behind");
  xtal_mode_a: assert property (
    mem_q[IDX_STAT2][ST2_XTAL] |=> int_mode == MODE_XTAL)
    else $error("crystal-rate mode not selected");

  read_status_c: cover property (rd_st1 ##[1:20] lnk.fall);
  full_write_c: cover property (
    wr_stb && cmd_q == CMD_FULL && byte_q == 3'h6);
  late_cmd_c: cover property (
    byte_end && state_q == ST_HUNT && !hunt_hit ##[1:300] hunt_hit);

endmodule
`default_nettype wire

// >>> rcp_pkg.sv
// Shared constants, types and decode helpers of the three-wire command port
`default_nettype none
package rcp_pkg;

  // ==========================================================================
  // Framing
  localparam logic [3:0] PREAMBLE   = 4'h6;
  localparam logic [2:0] CMD_STAT1  = 3'h0;
  localparam logic [2:0] CMD_STAT2  = 3'h1;
  localparam logic [2:0] CMD_FULL   = 3'h2;
  localparam logic [2:0] CMD_SHORT  = 3'h3;
  localparam logic [2:0] CMD_ALM1   = 3'h4;
  localparam logic [2:0] CMD_ALM2   = 3'h5;
  localparam logic [2:0] CMD_CORR   = 3'h6;
  localparam logic [2:0] CMD_FREE   = 3'h7;

  // ==========================================================================
  // Byte store layout (index into the register byte array)
  localparam int unsigned MEM_BYTES = 16;
  localparam logic [3:0] IDX_STAT2  = 4'h0;
  localparam logic [3:0] IDX_YEAR   = 4'h1;
  localparam logic [3:0] IDX_MONTH  = 4'h2;
  localparam logic [3:0] IDX_DAY    = 4'h3;
  localparam logic [3:0] IDX_WDAY   = 4'h4;
  localparam logic [3:0] IDX_HOUR   = 4'h5;
  localparam logic [3:0] IDX_A1WDAY = 4'h8;
  localparam logic [3:0] IDX_A2WDAY = 4'hb;
  localparam logic [3:0] IDX_CORR   = 4'he;
  localparam logic [3:0] IDX_FREE   = 4'hf;

  // ==========================================================================
  // Field positions
  localparam int unsigned ST1_RESET = 7;
  localparam int unsigned ST1_FMT   = 6;
  localparam int unsigned ST1_SC0   = 5;
  localparam int unsigned ST1_SC1   = 4;
  localparam int unsigned ST2_FREQ  = 7;
  localparam int unsigned ST2_PMIN  = 6;
  localparam int unsigned ST2_A1EN  = 5;
  localparam int unsigned ST2_XTAL  = 4;
  localparam int unsigned ST2_A2EN  = 1;

  // ==========================================================================
  // Transfer lengths and writable-bit masks
  localparam logic [3:0] LEN_ONE    = 4'h1;
  localparam logic [3:0] LEN_THREE  = 4'h3;
  localparam logic [3:0] LEN_FULL   = 4'h7;
  localparam logic [7:0] MASK_ALL   = 8'hff;
  localparam logic [7:0] MASK_MONTH = 8'hf8;
  localparam logic [7:0] MASK_DAY   = 8'hfc;
  localparam logic [7:0] MASK_WDAY  = 8'he0;
  localparam logic [7:0] MASK_TIME  = 8'hfe;
  localparam logic [7:0] MASK_AWDAY = 8'he1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic       RST_POC    = 1'b1;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_FREQ, MODE_MIN_EDGE, MODE_MIN_PER1,
    MODE_ALARM1, MODE_MIN_PER2, MODE_XTAL
  } rcp_int_mode_t;

  typedef enum logic [1:0] {ST_HUNT, ST_WRITE, ST_READ} rcp_state_t;

  // First store index reached by a command
  function automatic logic [3:0] cmd_base(input logic [2:0] cmd);
    case (cmd)
      CMD_FULL:  cmd_base = IDX_YEAR;
      CMD_SHORT: cmd_base = IDX_HOUR;
      CMD_ALM1:  cmd_base = IDX_A1WDAY;
      CMD_ALM2:  cmd_base = IDX_A2WDAY;
      CMD_CORR:  cmd_base = IDX_CORR;
      CMD_FREE:  cmd_base = IDX_FREE;
      default:   cmd_base = IDX_STAT2;
    endcase
  endfunction

  // Bytes moved by a command
  function automatic logic [3:0] cmd_len(input logic [2:0] cmd,
                                         input logic freq);
    case (cmd)
      CMD_FULL:  cmd_len = LEN_FULL;
      CMD_SHORT: cmd_len = LEN_THREE;
      CMD_ALM1:  cmd_len = freq ? LEN_ONE : LEN_THREE;
      CMD_ALM2:  cmd_len = LEN_THREE;
      default:   cmd_len = LEN_ONE;
    endcase
  endfunction

  // Bits of a stored byte that hold data; the rest read zero
  function automatic logic [7:0] mem_mask(input logic [3:0] idx,
                                          input logic freq);
    case (idx)
      IDX_MONTH:  mem_mask = MASK_MONTH;
      IDX_DAY:    mem_mask = MASK_DAY;
      IDX_WDAY:   mem_mask = MASK_WDAY;
      4'h5, 4'h6, 4'h7: mem_mask = MASK_TIME;
      IDX_A1WDAY: mem_mask = freq ? MASK_ALL : MASK_AWDAY;
      IDX_A2WDAY: mem_mask = MASK_AWDAY;
      default:    mem_mask = MASK_ALL;
    endcase
  endfunction

endpackage
`default_nettype wire

// >>> rcp_link_if.sv
// Synchronised serial link levels and clock edges between the port modules
`default_nettype none
interface rcp_link_if;
  logic sel;
  logic rise;
  logic fall;
  logic din;
  modport src (output sel, output rise, output fall, output din);
  modport dst (input sel, input rise, input fall, input din);
endinterface
`default_nettype wire

// >>> rcp_link_sync.sv
// Pin synchroniser and serial clock edge finder
`default_nettype none
module rcp_link_sync #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic cs_pin,
  input  wire logic sck_pin,
  input  wire logic sio_pin,
  rcp_link_if.src   lnk
);

  // ==========================================================================
  // Elaboration check
  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("rcp_link_sync needs at least two synchroniser stages");
  end

  logic [2:0] stg_q [SYNC_STAGES];
  logic [2:0] stg_d [SYNC_STAGES];
  logic       sck_last_q;
  logic       sck_last_d;

  // Chain of stages; stage 0 feeds only stage 1 to limit metastability
  always_comb begin
    stg_d[0] = {cs_pin, sck_pin, sio_pin};
    for (int i = 1; i < SYNC_STAGES; i++) begin
      stg_d[i] = stg_q[i-1];
    end
    sck_last_d = stg_q[SYNC_STAGES-1][1];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        stg_q[i] <= 3'h0;
      end
      sck_last_q <= 1'b0;
    end else begin
      stg_q      <= stg_d;
      sck_last_q <= sck_last_d;
    end
  end

  // Edges are found on the settled stage only
  assign lnk.sel  = stg_q[SYNC_STAGES-1][2];
  assign lnk.rise = stg_q[SYNC_STAGES-1][1] & ~sck_last_q;
  assign lnk.fall = ~stg_q[SYNC_STAGES-1][1] & sck_last_q;
  assign lnk.din  = stg_q[SYNC_STAGES-1][0];

endmodule
`default_nettype wire

// >>> rcp_host_model.sv
// Behavioural host that frames commands on the three-wire port
`default_nettype none
module rcp_host_model (
  input  wire logic ref_clk,
  output logic      cs_pin,
  output logic      sck_pin,
  output logic      sio_drv,
  input  wire logic sio_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] dat [0:7];

  // Clock idles high so the first edge of a frame is a fall
  initial begin
    cs_pin = 1'b0;
    sck_pin = 1'b1;
    sio_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // Byte 0 then n data bytes; read bytes are captured back into dat
  task automatic frame(input int n);
    logic rd;
    rd = dat[0][0];
    cs_pin <= 1'b1;
    tick(3);
    for (int b = 0; b <= n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        sck_pin <= 1'b0;
        tick(2);
        sio_drv <= (rd && b > 0) ? 1'b1 : dat[b][i];
        tick(3);
        sck_pin <= 1'b1;
        tick(2);
        if (rd && b > 0) begin
          dat[b][i] = sio_wire;
        end
        // Hold time is over: the pull-up takes the line back
        sio_drv <= 1'b1;
        tick(3);
      end
    end
    cs_pin <= 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

// >>> tb_rcp_cmd_port.sv
// Self-checking bench of the three-wire command port
`default_nettype none
module tb_rcp_cmd_port
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          ref_clk, resetn, cs_pin, sck_pin, host_sio, sio_line;
  logic          sio_o, sio_oe, a1_hit, a2_hit, lv_det;
  logic          hour_24_mode, init_pulse;
  logic [7:0]    status_two, rate_correction, user_free_byte;
  logic [55:0]   time_date;
  logic [23:0]   alarm_one_reg, alarm_two_reg;
  rcp_int_mode_t int_mode;
  int            n_errors, comparisons, n_init;

  // Open-drain line with pull-up: low while the host or the device pulls
  assign sio_line = host_sio & (sio_oe ? sio_o : 1'b1);

  rcp_host_model i_host (.ref_clk(ref_clk), .cs_pin(cs_pin),
    .sck_pin(sck_pin), .sio_drv(host_sio), .sio_wire(sio_line));

  rcp_cmd_port #(.SYNC_STAGES(2)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .cs_pin(cs_pin),
    .sck_pin(sck_pin), .sio_i(sio_line), .sio_o(sio_o),
    .sio_oe(sio_oe), .alarm_one_hit(a1_hit), .alarm_two_hit(a2_hit),
    .low_voltage_det(lv_det), .hour_24_mode(hour_24_mode),
    .status_two(status_two), .time_date(time_date),
    .alarm_one_reg(alarm_one_reg), .alarm_two_reg(alarm_two_reg),
    .rate_correction(rate_correction), .user_free_byte(user_free_byte),
    .int_mode(int_mode), .init_pulse(init_pulse));

  // ==========================================================================
  // Clock, pulse counter and helpers
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (init_pulse === 1'b1) n_init++;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic go(input logic [2:0] c, input logic d, input int n);
    i_host.dat[0] = {PREAMBLE, c, d};
    i_host.frame(n);
  endtask

  task automatic wr1(input logic [2:0] c, input logic [7:0] v);
    i_host.dat[1] = v;
    go(c, 1'b0, 1);
  endtask

  task automatic rd1(input logic [2:0] c, input logic [7:0] exp);
    go(c, 1'b1, 1);
    chk(i_host.dat[1], exp);
  endtask

  // One-cycle event pulse from timekeeping
  task automatic pulse(input int which);
    if (which == 1) a1_hit <= 1'b1;
    else if (which == 2) a2_hit <= 1'b1;
    else lv_det <= 1'b1;
    @(posedge ref_clk);
    a1_hit <= 1'b0;
    a2_hit <= 1'b0;
    lv_det <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic end_sim;
    $display("Errors %0d in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_power_on;
    rd1(CMD_STAT1, 8'h01);
    rd1(CMD_STAT1, 8'h00);
  endtask

  task automatic t_single;
    wr1(CMD_FREE, 8'ha5);
    chk(user_free_byte, 8'ha5);
    rd1(CMD_FREE, 8'ha5);
    wr1(CMD_CORR, 8'h3c);
    chk(rate_correction, 8'h3c);
    rd1(CMD_CORR, 8'h3c);
  endtask

  // Unused bits set on purpose in every byte but the year
  task automatic t_time;
    logic [55:0] e;
    i_host.dat[1:7] = '{8'h53, 8'h4f, 8'h97, 8'h5f, 8'h8b, 8'h4d, 8'h99};
    go(CMD_FULL, 1'b0, 7);
    e = 56'h53489440_8a4c98;
    chk(time_date, e);
    go(CMD_SHORT, 1'b1, 3);
    chk({i_host.dat[1], i_host.dat[2], i_host.dat[3]}, e[23:0]);
    i_host.dat[1:3] = '{8'h11, 8'h23, 8'h33};
    go(CMD_SHORT, 1'b0, 3);
    e[23:0] = 24'h102232;
    chk(time_date, e);
    go(CMD_FULL, 1'b1, 7);
    for (int i = 1; i <= 7; i++) begin
      chk(i_host.dat[i], e[63-8*i -: 8]);
    end
  endtask

  // Every pin mode; last entry leaves alarm one and two enabled
  task automatic t_mode;
    logic [7:0]    s2 [0:7];
    rcp_int_mode_t m [0:7];
    s2 = '{8'h00, 8'h80, 8'h40, 8'hc0, 8'h20, 8'he0, 8'h10, 8'h2e};
    m = '{MODE_NONE, MODE_FREQ, MODE_MIN_EDGE, MODE_MIN_PER1,
          MODE_ALARM1, MODE_MIN_PER2, MODE_XTAL, MODE_ALARM1};
    for (int i = 0; i < 8; i++) begin
      wr1(CMD_STAT2, s2[i]);
      chk(status_two, s2[i]);
      chk(int_mode, m[i]);
    end
    rd1(CMD_STAT2, 8'h2e);
  endtask

  task automatic t_alarm;
    i_host.dat[1:3] = '{8'hff, 8'hff, 8'hff};
    go(CMD_ALM1, 1'b0, 3);
    chk(alarm_one_reg, 24'he1ffff);
    i_host.dat[1:3] = '{8'h41, 8'h8b, 8'h4d};
    go(CMD_ALM2, 1'b0, 3);
    chk(alarm_two_reg, 24'h418b4d);
    go(CMD_ALM2, 1'b1, 3);
    chk({i_host.dat[1], i_host.dat[2], i_host.dat[3]}, 24'h418b4d);
    pulse(1);
    pulse(2);
    rd1(CMD_STAT1, 8'h0c);
    rd1(CMD_STAT1, 8'h00);
    wr1(CMD_STAT2, 8'h80);
    wr1(CMD_ALM1, 8'hff);
    chk(alarm_one_reg[23:16], 8'hff);
    rd1(CMD_ALM1, 8'hff);
    pulse(1);
    rd1(CMD_STAT1, 8'h00);
  endtask

  // Bad first byte, good second byte, then a frame never recognised
  task automatic t_preamble;
    i_host.dat[0:2] = '{8'h7e, 8'h6e, 8'h3c};
    i_host.frame(2);
    chk(user_free_byte, 8'h3c);
    i_host.dat[0:1] = '{8'h5e, 8'h11};
    i_host.frame(1);
    chk(user_free_byte, 8'h3c);
  endtask

  task automatic t_status1;
    int n0;
    wr1(CMD_STAT1, 8'h7f);
    chk(hour_24_mode, 1'b1);
    rd1(CMD_STAT1, 8'h70);
    pulse(3);
    rd1(CMD_STAT1, 8'h72);
    n0 = n_init;
    wr1(CMD_STAT1, 8'h80);
    chk(n_init - n0, 1);
    chk({hour_24_mode, user_free_byte, status_two}, 17'h0);
    rd1(CMD_STAT1, 8'h02);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    resetn = 1'b0;
    a1_hit = 1'b0;
    a2_hit = 1'b0;
    lv_det = 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_power_on();
    t_single();
    t_time();
    t_mode();
    t_alarm();
    t_preamble();
    t_status1();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
